// ### pisw_map.vh
// constants for the priority interrupt and standby wake block
`ifndef PISW_MAP_VH
`define PISW_MAP_VH

// vector slots, index 0..9 by address order
`define PISW_NUM_SLOTS     10
`define PISW_NUM_SRC       15
`define PISW_VEC_BASE      8'h03
`define PISW_VEC_STEP      8'h08
`define PISW_SLOT_UNUSED   4'd6

// priority levels
`define PISW_LVL_NONE      2'd0
`define PISW_LVL_LOW       2'd1
`define PISW_LVL_HIGH      2'd2
`define PISW_LVL_TOP       2'd3

// source bit positions in the request vector
`define PISW_SRC_PIN_A     0
`define PISW_SRC_PIN_B     1
`define PISW_SRC_PIN_C     2
`define PISW_SRC_CAPT_LO   3
`define PISW_SRC_PIN_E     4
`define PISW_SRC_PIN_D     5
`define PISW_SRC_BASE_TMR  6
`define PISW_SRC_CAPT_HI   7
`define PISW_SRC_PWM_LO    8
`define PISW_SRC_PWM_HI    9
`define PISW_SRC_SERIAL    10
`define PISW_SRC_ADC       11
`define PISW_SRC_TMR_SIX   12
`define PISW_SRC_TMR_SEVEN 13
`define PISW_SRC_PORT0     14

// standby mode request codes
`define PISW_SB_RUN        2'd0
`define PISW_SB_IDLE       2'd1
`define PISW_SB_DEEP       2'd2
`define PISW_SB_XTAL       2'd3

// oscillator enable bit positions
`define PISW_OSC_CF        0
`define PISW_OSC_SRC       1
`define PISW_OSC_RC        2
`define PISW_OSC_MRC       3
`define PISW_OSC_XTAL      4
`define PISW_OSC_W         5

`endif

// ### pisw_arbiter.v
// fixed-order arbiter: highest level wins, lowest slot breaks ties
`timescale 1ns/10ps
`include "pisw_map.vh"

module pisw_arbiter #(
  parameter NSLOT = `PISW_NUM_SLOTS
) (
  input  wire [NSLOT-1:0]   req,
  input  wire [2*NSLOT-1:0] lvl,
  input  wire [1:0]         floor_lvl,
  output reg                grant,
  output reg  [3:0]         grant_slot,
  output reg  [1:0]         grant_lvl
);

  integer i;

  always @* begin
    grant      = 1'b0;
    grant_slot = 4'h0;
    grant_lvl  = `PISW_LVL_NONE;
    // descending scan so a lower slot overwrites on equal level
    for (i = NSLOT - 1; i >= 0; i = i - 1) begin
      if (req[i] && (lvl[2*i +: 2] > floor_lvl) &&
          (lvl[2*i +: 2] >= grant_lvl)) begin
        grant      = 1'b1;
        grant_slot = i[3:0];
        grant_lvl  = lvl[2*i +: 2];
      end
    end
  end

endmodule

// ### pisw_ctrl.v
// interrupt arbitration, nesting and standby wake controller
`timescale 1ns/10ps
`include "pisw_map.vh"

// What this block does
// - three levels top over high over low; refuse requests not above current level
// - among simultaneous pending vectors grant the highest priority level
// - equal level ties go to the smallest vector address
// - fifteen sources on nine slots; pin a and b slots top or low, others high or low
// - idle standby stops execution, peripherals keep running
// - idle standby leaves each oscillator as osc_enable_sw sets it, the same as in run
// - idle ends on reset pin, low voltage, watchdog or accepted interrupt
// - deep standby stops execution, peripherals and every oscillator
// - deep ends on resets, pins a b c e, or port 0 request
// - pins a and b wake deep modes only when level sensitive
// - crystal standby keeps base timer and crystal state, stops other oscillators
// - crystal standby ends on resets, level pins a b, pins c e, port 0, base timer
// - base timer wakes crystal standby only when crystal is the clock source
module pisw_ctrl #(
  parameter NSRC  = `PISW_NUM_SRC,
  parameter NSLOT = `PISW_NUM_SLOTS,
  parameter DEPTH = 3
) (
  input  wire               clk,
  input  wire               reset,
  input  wire [NSRC-1:0]    src_req_pin,
  input  wire               ext_irq_pin_a_level,
  input  wire               ext_irq_pin_b_level,
  input  wire               ext_irq_pin_a_top,
  input  wire               ext_irq_pin_b_top,
  input  wire [NSLOT-1:0]   slot_high,
  input  wire [NSLOT-1:0]   slot_enable,
  input  wire               master_enable,
  input  wire               reset_pin_n,
  input  wire               lvd_reset,
  input  wire               wdt_reset,
  input  wire [1:0]         standby_req,
  input  wire               standby_go,
  input  wire               xtal_selected,
  input  wire               osc_run_xtal,
  input  wire [`PISW_OSC_W-1:0] osc_enable_sw,
  input  wire               vec_ack,
  input  wire               isr_return,
  output wire               vec_valid,
  output reg  [7:0]         vec_addr_q,
  output reg  [1:0]         vec_level_q,
  output reg  [1:0]         cur_level_q,
  output reg                cpu_run_q,
  output reg                periph_run_q,
  output reg                base_timer_run_q,
  output reg  [`PISW_OSC_W-1:0] osc_enable_q,
  output reg  [1:0]         standby_mode_q,
  output reg                system_reset_q
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  reg [NSRC-1:0] src_s1_q;
  reg [NSRC-1:0] src_q;
  reg [2:0]      rst_s1_q;
  reg [2:0]      rst_q;

  always @(posedge clk) begin
    if (reset) begin
      src_s1_q <= {NSRC{1'b0}};
      src_q    <= {NSRC{1'b0}};
      rst_s1_q <= 3'h0;
      rst_q    <= 3'h0;
    end else begin
      src_s1_q <= src_req_pin;
      src_q    <= src_s1_q;
      rst_s1_q <= {~reset_pin_n, lvd_reset, wdt_reset};
      rst_q    <= rst_s1_q;
    end
  end

  wire any_sys_reset = |rst_q;

  ////////////////////////////////////////////////////////////////////////////
  // source to slot grouping

  wire [NSLOT-1:0] slot_req_raw;
  assign slot_req_raw[0] = src_q[`PISW_SRC_PIN_A];
  assign slot_req_raw[1] = src_q[`PISW_SRC_PIN_B];
  assign slot_req_raw[2] = src_q[`PISW_SRC_PIN_C] | src_q[`PISW_SRC_CAPT_LO] |
                           src_q[`PISW_SRC_PIN_E];
  assign slot_req_raw[3] = src_q[`PISW_SRC_PIN_D] | src_q[`PISW_SRC_BASE_TMR];
  assign slot_req_raw[4] = src_q[`PISW_SRC_CAPT_HI];
  assign slot_req_raw[5] = src_q[`PISW_SRC_PWM_LO] | src_q[`PISW_SRC_PWM_HI];
  assign slot_req_raw[6] = 1'b0;
  assign slot_req_raw[7] = src_q[`PISW_SRC_SERIAL];
  assign slot_req_raw[8] = src_q[`PISW_SRC_ADC] | src_q[`PISW_SRC_TMR_SIX] |
                           src_q[`PISW_SRC_TMR_SEVEN];
  assign slot_req_raw[9] = src_q[`PISW_SRC_PORT0];

  wire [NSLOT-1:0] slot_req = slot_req_raw & slot_enable & {NSLOT{master_enable}};

  // slot level: pins a and b top or low, the rest high or low
  wire [2*NSLOT-1:0] slot_lvl;
  genvar g;
  generate
    for (g = 0; g < NSLOT; g = g + 1) begin : g_lvl
      if (g == 0) begin : g_a
        assign slot_lvl[2*g +: 2] = ext_irq_pin_a_top ? `PISW_LVL_TOP : `PISW_LVL_LOW;
      end else if (g == 1) begin : g_b
        assign slot_lvl[2*g +: 2] = ext_irq_pin_b_top ? `PISW_LVL_TOP : `PISW_LVL_LOW;
      end else begin : g_o
        assign slot_lvl[2*g +: 2] = slot_high[g] ? `PISW_LVL_HIGH : `PISW_LVL_LOW;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // arbitration and nesting stack

  wire       grant;
  wire [3:0] grant_slot;
  wire [1:0] grant_lvl;

  pisw_arbiter #(
    .NSLOT (NSLOT)
  ) u_arb (
    .req        (slot_req),
    .lvl        (slot_lvl),
    .floor_lvl  (cur_level_q),
    .grant      (grant),
    .grant_slot (grant_slot),
    .grant_lvl  (grant_lvl)
  );

  reg [1:0] lvl_stack_q [0:DEPTH-1];
  reg [1:0] sp_q;
  integer   k;

  // offered vector follows the arbiter each cycle and can change or drop before the sequencer takes it
  assign vec_valid = (standby_mode_q == `PISW_SB_RUN) && cpu_run_q && grant;

  always @(posedge clk) begin
    if (reset || any_sys_reset) begin
      vec_addr_q  <= 8'h00;
      vec_level_q <= `PISW_LVL_NONE;
      cur_level_q <= `PISW_LVL_NONE;
      sp_q        <= 2'h0;
      for (k = 0; k < DEPTH; k = k + 1) begin
        lvl_stack_q[k] <= `PISW_LVL_NONE;
      end
    end else begin
      vec_addr_q  <= `PISW_VEC_BASE + {grant_slot, 3'b000};
      vec_level_q <= grant_lvl;
      if (vec_valid && vec_ack) begin
        lvl_stack_q[sp_q] <= cur_level_q;
        sp_q              <= sp_q + 2'h1;
        cur_level_q       <= grant_lvl;
      end else if (isr_return && sp_q != 2'h0) begin
        sp_q        <= sp_q - 2'h1;
        cur_level_q <= lvl_stack_q[sp_q - 2'h1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // standby wake conditions

  // pins a and b wake deep modes only when level detection is chosen
  wire pin_ab_wake = (src_q[`PISW_SRC_PIN_A] & ext_irq_pin_a_level) |
                     (src_q[`PISW_SRC_PIN_B] & ext_irq_pin_b_level);
  wire deep_wake   = pin_ab_wake | src_q[`PISW_SRC_PIN_C] |
                     src_q[`PISW_SRC_PIN_E] | src_q[`PISW_SRC_PORT0];
  wire xtal_wake   = deep_wake |
                     (src_q[`PISW_SRC_BASE_TMR] & xtal_selected);
  wire idle_wake   = grant;

  ////////////////////////////////////////////////////////////////////////////
  // standby state machine, one-hot

  localparam ST_RUN  = 4'b0001;
  localparam ST_IDLE = 4'b0010;
  localparam ST_DEEP = 4'b0100;
  localparam ST_XTAL = 4'b1000;

  reg [3:0] st_q;
  reg [3:0] st_d;
  reg       xtal_keep_q;

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_RUN: begin
        if (standby_go) begin
          case (standby_req)
            `PISW_SB_IDLE: st_d = ST_IDLE;
            `PISW_SB_DEEP: st_d = ST_DEEP;
            `PISW_SB_XTAL: st_d = ST_XTAL;
            default:       st_d = ST_RUN;
          endcase
        end
      end
      ST_IDLE: if (idle_wake) st_d = ST_RUN;
      ST_DEEP: if (deep_wake) st_d = ST_RUN;
      ST_XTAL: if (xtal_wake) st_d = ST_RUN;
      default: st_d = ST_RUN;
    endcase
    if (any_sys_reset) begin
      st_d = ST_RUN;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      st_q             <= ST_RUN;
      xtal_keep_q      <= 1'b0;
      cpu_run_q        <= 1'b1;
      periph_run_q     <= 1'b1;
      base_timer_run_q <= 1'b1;
      osc_enable_q     <= {`PISW_OSC_W{1'b0}};
      standby_mode_q   <= `PISW_SB_RUN;
      system_reset_q   <= 1'b0;
    end else begin
      st_q           <= st_d;
      system_reset_q <= any_sys_reset;
      if (st_q == ST_RUN && st_d == ST_XTAL) begin
        xtal_keep_q <= osc_run_xtal;
      end
      case (st_d)
        ST_IDLE: begin
          cpu_run_q        <= 1'b0;
          periph_run_q     <= 1'b1;
          base_timer_run_q <= 1'b1;
          osc_enable_q     <= osc_enable_sw;
          standby_mode_q   <= `PISW_SB_IDLE;
        end
        ST_DEEP: begin
          cpu_run_q        <= 1'b0;
          periph_run_q     <= 1'b0;
          base_timer_run_q <= 1'b0;
          osc_enable_q     <= {`PISW_OSC_W{1'b0}};
          standby_mode_q   <= `PISW_SB_DEEP;
        end
        ST_XTAL: begin
          cpu_run_q        <= 1'b0;
          periph_run_q     <= 1'b0;
          base_timer_run_q <= 1'b1;
          osc_enable_q     <= {`PISW_OSC_W{1'b0}};
          // crystal keeps its entry state; other sources stop
          osc_enable_q[`PISW_OSC_XTAL] <= (st_q == ST_RUN) ? osc_run_xtal : xtal_keep_q;
          standby_mode_q   <= `PISW_SB_XTAL;
        end
        default: begin
          cpu_run_q        <= 1'b1;
          periph_run_q     <= 1'b1;
          base_timer_run_q <= 1'b1;
          osc_enable_q     <= osc_enable_sw;
          standby_mode_q   <= `PISW_SB_RUN;
        end
      endcase
    end
  end

endmodule

// ### pisw_ctrl_properties.sv
// checker for the priority interrupt and standby wake controller
`timescale 1ns/10ps
`include "pisw_map.vh"
module pisw_ctrl_chk (
  input logic                   clk,
  input logic                   reset,
  input logic                   vec_valid,
  input logic                   vec_ack,
  input logic                   standby_go,
  input logic [1:0]             standby_req,
  input logic [1:0]             vec_level_q,
  input logic [1:0]             cur_level_q,
  input logic                   cpu_run_q,
  input logic                   periph_run_q,
  input logic                   base_timer_run_q,
  input logic [`PISW_OSC_W-1:0] osc_enable_q,
  input logic [1:0]             standby_mode_q,
  input logic                   system_reset_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ack_level_a: assert property (
    vec_valid && vec_ack && $past(vec_valid) |=> cur_level_q == $past(vec_level_q))
    else $error("serviced level differs from offer");
  top_blocks_a: assert property (
    cur_level_q == `PISW_LVL_TOP |-> !vec_valid) else $error("offer above top level");
  idle_run_a: assert property (
    standby_mode_q == `PISW_SB_IDLE |-> !cpu_run_q && periph_run_q)
    else $error("idle run enables wrong");
  idle_osc_a: assert property (
    standby_go && standby_req == `PISW_SB_IDLE && standby_mode_q == `PISW_SB_RUN
    |=> $stable(osc_enable_q)) else $error("idle entry changed oscillators");
  deep_stop_a: assert property (
    standby_mode_q == `PISW_SB_DEEP |-> !cpu_run_q && !periph_run_q && osc_enable_q == 5'h00)
    else $error("deep standby left something running");
  xtal_keep_a: assert property (
    standby_mode_q == `PISW_SB_XTAL |-> base_timer_run_q && !periph_run_q && !cpu_run_q
    && osc_enable_q[3:0] == 4'h0) else $error("crystal standby enables wrong");
  mode_enter_a: assert property (
    standby_go && standby_mode_q == `PISW_SB_RUN && !system_reset_q
    |=> standby_mode_q == $past(standby_req)) else $error("standby mode not entered");
  sysrst_run_a: assert property (
    system_reset_q |=> standby_mode_q == `PISW_SB_RUN && cur_level_q == `PISW_LVL_NONE)
    else $error("system reset did not return to run");
  run_cpu_a: assert property (
    standby_mode_q == `PISW_SB_RUN |-> cpu_run_q) else $error("cpu stopped in run");
endmodule
bind pisw_ctrl pisw_ctrl_chk u_chk (.clk, .reset, .vec_valid, .vec_ack, .standby_go,
  .standby_req, .vec_level_q, .cur_level_q, .cpu_run_q, .periph_run_q, .base_timer_run_q,
  .osc_enable_q, .standby_mode_q, .system_reset_q);

// ### pisw_seq_model.sv
// sequencer model: takes offered vectors after a set wait
`timescale 1ns/10ps
module pisw_seq_model (
  input  logic       clk,
  input  logic       reset,
  input  logic       vec_valid,
  input  logic [7:0] vec_addr_q,
  input  logic [3:0] wait_cyc,
  output logic       vec_ack,
  output logic       took_q,
  output logic [7:0] took_addr_q
);
  logic [3:0] cnt_q;
  // ack only once the offer stood a cycle, so the address is settled
  always @(posedge clk) begin
    took_q <= vec_valid && vec_ack;
    if (vec_valid && vec_ack)
      took_addr_q <= vec_addr_q;
    if (reset || !vec_valid || vec_ack) begin
      vec_ack <= 1'b0;
      cnt_q   <= 4'h0;
    end else if (cnt_q == wait_cyc)
      vec_ack <= 1'b1;
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule

// ### tb_top.sv
// testbench for the priority interrupt and standby wake controller
`timescale 1ns/10ps
`include "pisw_map.vh"
`define CHK(a,b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t got %h exp %h", $time, a, b); end end
module tb_top;
  localparam [59:0] SLOT_TAB = 60'h988875543322210;
  logic clk = 0, reset = 1, ext_irq_pin_a_level = 0, ext_irq_pin_b_level = 0;
  logic ext_irq_pin_a_top = 0, reset_pin_n = 1, lvd_reset = 0, wdt_reset = 0;
  logic ext_irq_pin_b_top = 0, osc_run_xtal = 1;
  logic standby_go = 0, xtal_selected = 0, isr_return = 0;
  logic [14:0] src = 15'h0000;
  logic [9:0]  slot_high = 10'h000;
  logic [1:0]  standby_req = 2'h0;
  logic [3:0]  wait_cyc = 4'h0;
  logic [4:0]  o;
  wire         vec_ack, vec_valid, took_q, cpu_run_q, periph_run_q, base_timer_run_q, sysrst;
  wire [7:0]   vec_addr_q, taddr;
  wire [1:0]   cur, mode;
  wire [4:0]   osc_enable_q;
  int          n_mismatch = 0, tests_run = 0;
  pisw_ctrl DUT (.clk, .reset, .src_req_pin(src), .ext_irq_pin_a_level,
    .ext_irq_pin_b_level, .ext_irq_pin_a_top, .ext_irq_pin_b_top, .slot_high,
    .slot_enable(10'h3ff), .master_enable(1'b1), .reset_pin_n, .lvd_reset, .wdt_reset,
    .standby_req, .standby_go, .xtal_selected, .osc_run_xtal,
    .osc_enable_sw(5'h1f), .vec_ack, .isr_return, .vec_valid, .vec_addr_q,
    .vec_level_q(), .cur_level_q(cur), .cpu_run_q, .periph_run_q, .base_timer_run_q,
    .osc_enable_q, .standby_mode_q(mode), .system_reset_q(sysrst));
  pisw_seq_model u_seq (.clk, .reset, .vec_valid, .vec_addr_q, .wait_cyc, .vec_ack,
    .took_q, .took_addr_q(taddr));
  always #50 clk = ~clk;
  task automatic cyc(input int n); repeat (n) @(posedge clk); endtask
  task automatic ret1; @(posedge clk) isr_return <= 1; @(posedge clk) isr_return <= 0; endtask
  task automatic clr;
    @(posedge clk) begin src <= 15'h0000; wait_cyc <= 4'h0; end
    cyc(4); repeat (3) ret1; cyc(4);
  endtask
  task automatic took(input logic [7:0] ea, input logic [1:0] el);
    for (int k = 0; k < 30 && took_q !== 1'b1; k++) @(negedge clk);
    // a stale address would otherwise pass when two sources share a slot
    `CHK(took_q, 1'b1)
    `CHK(taddr, ea)
    `CHK(cur, el)
  endtask
  task automatic take(input int s, input logic [7:0] ea, input logic [1:0] el);
    @(posedge clk) src[s] <= 1'b1;
    took(ea, el);
    @(posedge clk) src[s] <= 1'b0;
    cyc(3);
  endtask
  task automatic go(input logic [1:0] m);
    o = osc_enable_q;
    @(posedge clk) begin standby_req <= m; standby_go <= 1; end
    @(posedge clk) standby_go <= 0;
    @(negedge clk) `CHK(mode, m)
  endtask
  task automatic wmode(input logic [1:0] m);
    for (int k = 0; k < 20 && mode !== m; k++) @(negedge clk);
    `CHK(mode, m)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_map;
    for (int i = 0; i < 15; i++) begin
      take(i, 8'h03 + {SLOT_TAB[i*4+:4], 3'h0}, `PISW_LVL_LOW);
      ret1;
    end
    $display("map test done");
  endtask
  task automatic t_nest;
    @(posedge clk) begin ext_irq_pin_a_top <= 1; slot_high <= 10'h310; end
    take(`PISW_SRC_SERIAL, 8'h3b, `PISW_LVL_LOW);
    @(posedge clk) src[`PISW_SRC_PWM_LO] <= 1;
    cyc(5);
    @(negedge clk) `CHK(vec_valid, 1'b0)
    take(`PISW_SRC_CAPT_HI, 8'h23, `PISW_LVL_HIGH);
    take(`PISW_SRC_PIN_A, 8'h03, `PISW_LVL_TOP);
    clr;
    `CHK(cur, `PISW_LVL_NONE)
    $display("nest test done");
  endtask
  task automatic t_arb;
    @(posedge clk) begin wait_cyc <= 4'h3; src <= 15'h4808; end
    took(8'h43, `PISW_LVL_HIGH);
    @(posedge clk) src[`PISW_SRC_ADC] <= 0;
    cyc(3); ret1;
    took(8'h4b, `PISW_LVL_HIGH);
    @(posedge clk) src[`PISW_SRC_PORT0] <= 0;
    cyc(3); ret1;
    took(8'h13, `PISW_LVL_LOW);
    clr;
    @(posedge clk) begin ext_irq_pin_a_top <= 0; ext_irq_pin_b_top <= 1; src <= 15'h0003; end
    took(8'h0b, `PISW_LVL_TOP);
    clr;
    $display("arbitration test done");
  endtask
  task automatic t_standby;
    int w[3] = '{2, 4, 14};
    go(`PISW_SB_IDLE);
    `CHK({cpu_run_q, periph_run_q, osc_enable_q}, {2'b01, o})
    take(`PISW_SRC_SERIAL, 8'h3b, `PISW_LVL_LOW);
    `CHK(mode, `PISW_SB_RUN)
    clr;
    go(`PISW_SB_DEEP);
    `CHK({cpu_run_q, periph_run_q, osc_enable_q}, 7'h00)
    @(posedge clk) src <= 15'h0403;
    cyc(8);
    @(negedge clk) `CHK(mode, `PISW_SB_DEEP)
    @(posedge clk) begin ext_irq_pin_a_level <= 1; ext_irq_pin_b_level <= 1; end
    wmode(`PISW_SB_RUN);
    clr;
    for (int j = 0; j < 3; j++) begin
      go(`PISW_SB_DEEP);
      @(posedge clk) src[w[j]] <= 1;
      wmode(`PISW_SB_RUN);
      clr;
    end
    go(`PISW_SB_XTAL);
    `CHK({base_timer_run_q, cpu_run_q, osc_enable_q[4]}, 3'b101)
    @(posedge clk) begin src[`PISW_SRC_BASE_TMR] <= 1; osc_run_xtal <= 0; end
    cyc(8);
    @(negedge clk) `CHK(mode, `PISW_SB_XTAL)
    `CHK(osc_enable_q[4], 1'b1)
    @(posedge clk) xtal_selected <= 1;
    wmode(`PISW_SB_RUN);
    clr;
    $display("standby test done");
  endtask
  task automatic t_rst;
    for (int k = 0; k < 3; k++) begin
      go(2'(k + 1));
      if (k == 2) `CHK(osc_enable_q[4], 1'b0)
      @(posedge clk) {reset_pin_n, lvd_reset, wdt_reset} <= 3'b100 ^ (3'b100 >> k);
      cyc(3);
      @(negedge clk) `CHK(sysrst, 1'b1)
      @(posedge clk) {reset_pin_n, lvd_reset, wdt_reset} <= 3'b100;
      wmode(`PISW_SB_RUN);
      cyc(4);
    end
    $display("reset wake test done");
  endtask
  task automatic print_verdict;
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    cyc(16);
    reset <= 0;
    cyc(2);
    t_map; t_nest; t_arb; t_standby; t_rst;
    print_verdict;
  end
  // run needs about 480 cycles; generous margin
  initial begin
    #800000;
    n_mismatch++;
    print_verdict;
  end
endmodule
